// ===== tlsf_pkg.sv
package tlsf_pkg;
  // setting width and range, in percent of rated torque
  localparam int          PCT_W        = 16;
  localparam logic [15:0] PCT_MAX      = 16'h0320;
  // reset values
  localparam logic [15:0] RST_SEL      = 16'h0000;
  localparam logic [15:0] RST_INT_LIM  = 16'h0320;
  localparam logic [15:0] RST_EXT_LIM  = 16'h0064;
  localparam logic [15:0] RST_MOT_MAX  = 16'h0320;
  // register byte offsets
  localparam logic [7:0]  OFS_SEL      = 8'h00;
  localparam logic [7:0]  OFS_FWD_INT  = 8'h04;
  localparam logic [7:0]  OFS_REV_INT  = 8'h08;
  localparam logic [7:0]  OFS_FWD_EXT  = 8'h0c;
  localparam logic [7:0]  OFS_REV_EXT  = 8'h10;
  localparam logic [7:0]  OFS_MOT_MAX  = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STS  = 8'h18;
  localparam logic [7:0]  OFS_IRQ_MSK  = 8'h1c;
  localparam logic [7:0]  OFS_IN_MON   = 8'h20;
  localparam logic [7:0]  OFS_OUT_MON  = 8'h24;
  localparam logic [7:0]  OFS_EFF_LIM  = 8'h28;
  // field positions
  localparam int          SEL_DIG_LSB  = 0;
  localparam int          MON_FWD_BIT  = 6;
  localparam int          MON_REV_BIT  = 7;
  localparam int          IRQ_RISE_BIT = 0;
  localparam int          IRQ_FALL_BIT = 1;
  localparam int          IRQ_W        = 2;
  // axi responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // lowest digit of the second output selection
  typedef enum logic [3:0] {
    ROUTE_NONE  = 4'h0,
    ROUTE_ONE   = 4'h1,
    ROUTE_TWO   = 4'h2,
    ROUTE_THREE = 4'h3
  } tlsf_route_e;

  // forward and reverse limits travelling together
  typedef struct packed {
    logic [PCT_W-1:0] fwd;
    logic [PCT_W-1:0] rev;
  } tlsf_limits_s;
endpackage

// ===== tlsf_top.sv
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
// Behaviour
// - flag asserted while reference exceeds limit
// - flag released when reference within limit
// - output circuits active low
// - route digit zero drives no circuit
// - route digit 1..3 selects circuit
// - shared circuit ORs all signals
// - forward input low applies forward external
// - forward input high ignores forward external
// - reverse input low applies reverse external
// - reverse input high ignores reverse external
// - forward external 0..800, default 100
// - reverse external 0..800, default 100
// - compared limit: lower of internal and active external
// - monitors show inputs at 6,7 and outputs
// - settings are percent of rated torque
// - internal limits 0..800, default 800
// - limit capped at motor maximum torque
module tlsf_top #(
  parameter int NUM_CIRC = 3
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic [15:0] TORQUE_REF_IN,
  input  wire logic        FWD_EXT_LIMIT_N_IN,
  input  wire logic        REV_EXT_LIMIT_N_IN,
  input  wire logic [NUM_CIRC-1:0] OTHER_CIRCUIT_IN,
  output logic [NUM_CIRC-1:0] OUT_CIRCUIT_N_OUT,
  output logic [15:0]      FWD_LIMIT_OUT,
  output logic [15:0]      REV_LIMIT_OUT,
  output logic             IRQ_OUT,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);
  // route digit is four bits, so at most fifteen circuits
  if (NUM_CIRC < 3 || NUM_CIRC > 15) begin : g_bad_num_circ
    $error("NUM_CIRC must be 3 to 15");
  end

  typedef logic [15:0] tlsf_pct_t;

  // settings and state
  tlsf_pct_t                  sel_r, fwd_int_r, rev_int_r;
  tlsf_pct_t                  fwd_ext_r, rev_ext_r, mot_max_r;
  logic [tlsf_pkg::IRQ_W-1:0] sts_r, msk_r;
  logic                       flag_r, irq_r;
  logic [NUM_CIRC-1:0]        circ_n_r;
  tlsf_pkg::tlsf_limits_s     eff_r;
  logic                       fwd_on_r, rev_on_r;

  // bus state
  logic        awrdy_r, wrdy_r, bvalid_r, ardy_r, rvalid_r;
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r, rresp_r;

  // write channel handshakes, address and data in either order
  wire         aw_hs    = AWVALID & awrdy_r;
  wire         w_hs     = WVALID & wrdy_r;
  wire         have_aw  = aw_hold_r | aw_hs;
  wire         have_w   = w_hold_r | w_hs;
  wire         do_wr    = have_aw & have_w;
  wire [7:0]   wa       = aw_hs ? AWADDR : awaddr_r;
  wire [31:0]  wd       = w_hs ? WDATA : wdata_r;
  wire [3:0]   ws       = w_hs ? WSTRB : wstrb_r;
  wire         aw_h_nxt = have_aw & ~do_wr;
  wire         w_h_nxt  = have_w & ~do_wr;
  wire         bv_nxt   = do_wr | (bvalid_r & ~BREADY);
  wire         ar_hs    = ARVALID & ardy_r;
  wire         rv_nxt   = ar_hs | (rvalid_r & ~RREADY);

  // write address decode
  wire wr_sel  = do_wr & (wa == tlsf_pkg::OFS_SEL);
  wire wr_fint = do_wr & (wa == tlsf_pkg::OFS_FWD_INT);
  wire wr_rint = do_wr & (wa == tlsf_pkg::OFS_REV_INT);
  wire wr_fext = do_wr & (wa == tlsf_pkg::OFS_FWD_EXT);
  wire wr_rext = do_wr & (wa == tlsf_pkg::OFS_REV_EXT);
  wire wr_max  = do_wr & (wa == tlsf_pkg::OFS_MOT_MAX);
  wire wr_sts  = do_wr & (wa == tlsf_pkg::OFS_IRQ_STS);
  wire wr_msk  = do_wr & (wa == tlsf_pkg::OFS_IRQ_MSK);
  wire wr_ok   = wr_sel | wr_fint | wr_rint | wr_fext | wr_rext |
                 wr_max | wr_sts | wr_msk;

  // byte-lane merge of a 16-bit setting
  function automatic tlsf_pct_t merge(tlsf_pct_t old,
                                      logic [31:0] d,
                                      logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // internal and external limit settings saturate at the top of their range
  function automatic tlsf_pct_t sat(tlsf_pct_t v);
    sat = (v > tlsf_pkg::PCT_MAX) ? tlsf_pkg::PCT_MAX : v;
  endfunction

  function automatic tlsf_pct_t min2(tlsf_pct_t a, tlsf_pct_t b);
    min2 = (a < b) ? a : b;
  endfunction

  wire tlsf_pct_t fint_wv = sat(merge(fwd_int_r, wd, ws));
  wire tlsf_pct_t rint_wv = sat(merge(rev_int_r, wd, ws));
  wire tlsf_pct_t fext_wv = sat(merge(fwd_ext_r, wd, ws));
  wire tlsf_pct_t rext_wv = sat(merge(rev_ext_r, wd, ws));

  // external inputs, active low
  wire fwd_on = ~FWD_EXT_LIMIT_N_IN;
  wire rev_on = ~REV_EXT_LIMIT_N_IN;

  // limits in force, percent of rated torque
  wire tlsf_pct_t fwd_cap = min2(fwd_int_r, mot_max_r);
  wire tlsf_pct_t rev_cap = min2(rev_int_r, mot_max_r);
  wire tlsf_pct_t fext_cap = min2(fwd_ext_r, mot_max_r);
  wire tlsf_pct_t rext_cap = min2(rev_ext_r, mot_max_r);
  wire tlsf_pct_t fwd_eff = fwd_on ? min2(fwd_cap, fext_cap)
                                   : fwd_cap;
  wire tlsf_pct_t rev_eff = rev_on ? min2(rev_cap, rext_cap)
                                   : rev_cap;

  // reference magnitude, sign gives direction
  wire        ref_neg = TORQUE_REF_IN[15];
  wire [16:0] ref_mag = ref_neg ? (17'h00000 - {1'b1, TORQUE_REF_IN})
                                : {1'b0, TORQUE_REF_IN};
  wire        lim_hit = ref_neg ? (ref_mag > {1'b0, rev_eff})
                                : (ref_mag > {1'b0, fwd_eff});

  // route digit and circuit drive
  wire [3:0] route = sel_r[tlsf_pkg::SEL_DIG_LSB +: 4];
  logic [NUM_CIRC-1:0] circ_n_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CIRC; gi++) begin : g_circ
      assign circ_n_nxt[gi] = ~((lim_hit & (route == 4'(gi + 1))) |
                                OTHER_CIRCUIT_IN[gi]);
    end
  endgenerate

  // interrupt status, set beats clear
  wire [1:0] ev      = {flag_r & ~lim_hit, lim_hit & ~flag_r};
  wire [1:0] sts_nxt = (sts_r & ~(wr_sts ? wd[1:0] : 2'h0)) | ev;
  wire [1:0] msk_nxt = wr_msk ? wd[1:0] : msk_r;

  // monitors
  wire [31:0] in_mon  = {24'h000000, rev_on_r, fwd_on_r,
                         6'h00};
  wire [31:0] out_mon = {28'h0000000, flag_r,
                         3'(~circ_n_r[2:0])};

  // read decode
  wire [7:0]  ra = ARADDR;
  wire        rd_ok = (ra <= tlsf_pkg::OFS_EFF_LIM) & (ra[1:0] == 2'h0);
  wire [31:0] rd_mux =
    (ra == tlsf_pkg::OFS_SEL)     ? {16'h0000, sel_r} :
    (ra == tlsf_pkg::OFS_FWD_INT) ? {16'h0000, fwd_int_r} :
    (ra == tlsf_pkg::OFS_REV_INT) ? {16'h0000, rev_int_r} :
    (ra == tlsf_pkg::OFS_FWD_EXT) ? {16'h0000, fwd_ext_r} :
    (ra == tlsf_pkg::OFS_REV_EXT) ? {16'h0000, rev_ext_r} :
    (ra == tlsf_pkg::OFS_MOT_MAX) ? {16'h0000, mot_max_r} :
    (ra == tlsf_pkg::OFS_IRQ_STS) ? {30'h0, sts_r} :
    (ra == tlsf_pkg::OFS_IRQ_MSK) ? {30'h0, msk_r} :
    (ra == tlsf_pkg::OFS_IN_MON)  ? in_mon :
    (ra == tlsf_pkg::OFS_OUT_MON) ? out_mon :
    (ra == tlsf_pkg::OFS_EFF_LIM) ? {eff_r.rev, eff_r.fwd} :
                                    32'h00000000;

  // write channel registers
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awrdy_r   <= 1'b0;
      wrdy_r    <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= tlsf_pkg::RESP_OKAY;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
    end else begin
      aw_hold_r <= aw_h_nxt;
      w_hold_r  <= w_h_nxt;
      awrdy_r   <= ~aw_h_nxt & ~bv_nxt;
      wrdy_r    <= ~w_h_nxt & ~bv_nxt;
      bvalid_r  <= bv_nxt;
      if (aw_hs) awaddr_r <= AWADDR;
      if (w_hs) wdata_r <= WDATA;
      if (w_hs) wstrb_r <= WSTRB;
      if (do_wr) bresp_r <= wr_ok ? tlsf_pkg::RESP_OKAY
                                  : tlsf_pkg::RESP_SLVERR;
    end
  end

  // read channel registers
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ardy_r   <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= tlsf_pkg::RESP_OKAY;
    end else begin
      ardy_r   <= ~rv_nxt;
      rvalid_r <= rv_nxt;
      if (ar_hs) rdata_r <= rd_ok ? rd_mux : 32'h00000000;
      if (ar_hs) rresp_r <= rd_ok ? tlsf_pkg::RESP_OKAY
                                  : tlsf_pkg::RESP_SLVERR;
    end
  end

  // settings
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sel_r     <= tlsf_pkg::RST_SEL;
      fwd_int_r <= tlsf_pkg::RST_INT_LIM;
      rev_int_r <= tlsf_pkg::RST_INT_LIM;
      fwd_ext_r <= tlsf_pkg::RST_EXT_LIM;
      rev_ext_r <= tlsf_pkg::RST_EXT_LIM;
      mot_max_r <= tlsf_pkg::RST_MOT_MAX;
      msk_r     <= 2'h0;
    end else begin
      if (wr_sel) sel_r <= merge(sel_r, wd, ws);
      if (wr_fint) fwd_int_r <= fint_wv;
      if (wr_rint) rev_int_r <= rint_wv;
      if (wr_fext) fwd_ext_r <= fext_wv;
      if (wr_rext) rev_ext_r <= rext_wv;
      if (wr_max) mot_max_r <= merge(mot_max_r, wd, ws);
      msk_r <= msk_nxt;
    end
  end

  // flag, circuits, limits, interrupt
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      flag_r   <= 1'b0;
      circ_n_r <= '1;
      eff_r    <= '0;
      fwd_on_r <= 1'b0;
      rev_on_r <= 1'b0;
      sts_r    <= 2'h0;
      irq_r    <= 1'b0;
    end else begin
      flag_r   <= lim_hit;
      circ_n_r <= circ_n_nxt;
      eff_r    <= '{fwd: fwd_eff, rev: rev_eff};
      fwd_on_r <= fwd_on;
      rev_on_r <= rev_on;
      sts_r    <= sts_nxt;
      irq_r    <= |(sts_nxt & msk_nxt);
    end
  end

  assign OUT_CIRCUIT_N_OUT = circ_n_r;
  assign FWD_LIMIT_OUT     = eff_r.fwd;
  assign REV_LIMIT_OUT     = eff_r.rev;
  assign IRQ_OUT           = irq_r;
  assign AWREADY           = awrdy_r;
  assign WREADY            = wrdy_r;
  assign BVALID            = bvalid_r;
  assign BRESP             = bresp_r;
  assign ARREADY           = ardy_r;
  assign RVALID            = rvalid_r;
  assign RDATA             = rdata_r;
  assign RRESP             = rresp_r;

  // checks start one cycle after reset so $past sees run values
  logic chk_live_r;
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      chk_live_r <= 1'b0;
    end else begin
      chk_live_r <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN || !chk_live_r);

  property p_flag_set;
    lim_hit |=> flag_r ##0 out_mon[3];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set on limit");

  property p_flag_clr;
    !lim_hit ##1 !lim_hit |-> !flag_r;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("flag stuck while within limit");

  property p_low_active;
    (route == tlsf_pkg::ROUTE_ONE) && lim_hit |=> !OUT_CIRCUIT_N_OUT[0];
  endproperty
  a_low_active: assert property (p_low_active)
    else $error("circuit one not pulled low");

  property p_route_none;
    (route == tlsf_pkg::ROUTE_NONE) && !(|OTHER_CIRCUIT_IN)
      |=> &OUT_CIRCUIT_N_OUT;
  endproperty
  a_route_none: assert property (p_route_none)
    else $error("flag reached a circuit with route zero");

  property p_route_sel;
    (route == tlsf_pkg::ROUTE_THREE) && lim_hit && !OTHER_CIRCUIT_IN[0]
      |=> !OUT_CIRCUIT_N_OUT[2] && OUT_CIRCUIT_N_OUT[0];
  endproperty
  a_route_sel: assert property (p_route_sel)
    else $error("flag on wrong circuit");

  property p_or;
    OTHER_CIRCUIT_IN[1] |=> !OUT_CIRCUIT_N_OUT[1];
  endproperty
  a_or: assert property (p_or)
    else $error("shared circuit not ORed");

  property p_fwd_ext;
    !FWD_EXT_LIMIT_N_IN |=> FWD_LIMIT_OUT <= $past(fext_cap);
  endproperty
  a_fwd_ext: assert property (p_fwd_ext)
    else $error("forward external limit not applied");

  property p_fwd_off;
    FWD_EXT_LIMIT_N_IN |=> FWD_LIMIT_OUT == $past(fwd_cap);
  endproperty
  a_fwd_off: assert property (p_fwd_off)
    else $error("forward external limit applied while off");

  property p_rev;
    ##1 ($past(REV_EXT_LIMIT_N_IN) ? (REV_LIMIT_OUT == $past(rev_cap))
                                   : (REV_LIMIT_OUT <= $past(rext_cap)));
  endproperty
  a_rev: assert property (p_rev)
    else $error("reverse limit selection wrong");

  property p_range;
    fwd_ext_r <= tlsf_pkg::PCT_MAX && rev_ext_r <= tlsf_pkg::PCT_MAX;
  endproperty
  a_range: assert property (p_range)
    else $error("external limit out of range");

  property p_cap;
    fwd_eff <= mot_max_r && rev_eff <= mot_max_r && fwd_eff <= fwd_int_r;
  endproperty
  a_cap: assert property (p_cap)
    else $error("limit above cap");

  property p_mon;
    ##1 in_mon[tlsf_pkg::MON_FWD_BIT] == !$past(FWD_EXT_LIMIT_N_IN);
  endproperty
  a_mon: assert property (p_mon)
    else $error("input monitor stale");

  c_flag_rise: cover property (!flag_r ##1 flag_r);
  c_write: cover property (do_wr ##1 BVALID && BREADY);
  c_route3: cover property ((route == tlsf_pkg::ROUTE_THREE) && flag_r);
  c_irq: cover property (!IRQ_OUT ##1 IRQ_OUT);
endmodule // tlsf_top

// ===== tlsf_host_model.sv
`timescale 1ns/1ns
// host controller side: contacts, reference and other allocated signals
module tlsf_host_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        go_in,
  input  wire logic [3:0]  lag_in,
  input  wire logic        share_in,
  input  wire logic [3:0]  route_in,
  input  wire logic [15:0] ref_in,
  input  wire logic        fwd_on_in,
  input  wire logic        rev_on_in,
  input  wire logic [2:0]  other_in,
  output logic             done_out,
  output logic [15:0]      ref_out,
  output logic             fwd_n_out,
  output logic             rev_n_out,
  output logic [2:0]       other_out
);
  logic       busy_r;
  logic [3:0] wait_r;

  // command applied lag plus one cycles after go, contacts off while in reset
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_r <= 1'b0;
      wait_r <= 4'h0;
      done_out <= 1'b0;
      ref_out <= 16'h0000;
      fwd_n_out <= 1'b1;
      rev_n_out <= 1'b1;
      other_out <= 3'h0;
    end else if (go_in) begin
      busy_r <= 1'b1;
      wait_r <= lag_in;
      done_out <= 1'b0;
    end else if (busy_r && wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end else if (busy_r) begin
      busy_r <= 1'b0;
      done_out <= 1'b1;
      ref_out <= ref_in;
      fwd_n_out <= ~fwd_on_in;
      rev_n_out <= ~rev_on_in;
      // other signals kept off the flag circuit unless sharing wanted
      other_out <= share_in ? other_in
                 : other_in & ~(3'h1 << (route_in - 4'h1));
    end else begin
      done_out <= 1'b0;
    end
  end
endmodule // tlsf_host_model

// ===== tlsf_top_tb.sv
`timescale 1ns/1ns
// self-checking bench for the torque limit flag block
module tlsf_top_tb;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, fwd_n, rev_n, go, done;
  logic        share, fon, ron, fl;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [2:0]  circ_n, other_w, coth, oe, ec;
  logic [15:0] fwd_lim, rev_lim, ref_w, cref, ef, er;
  logic [3:0]  lag, route;
  logic [15:0] v[6];
  logic [7:0]  ofs[6];
  logic [31:0] rstv[12];
  logic [33:0] expq[$];
  int          mismatches, n_compared, it, k, rv;

  tlsf_top u_tlsf_top (.CLK_SYS_IN(clk), .SYS_RST_IN(rst),
    .TORQUE_REF_IN(ref_w), .FWD_EXT_LIMIT_N_IN(fwd_n),
    .REV_EXT_LIMIT_N_IN(rev_n), .OTHER_CIRCUIT_IN(other_w),
    .OUT_CIRCUIT_N_OUT(circ_n), .FWD_LIMIT_OUT(fwd_lim),
    .REV_LIMIT_OUT(rev_lim), .IRQ_OUT(irq), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready));

  tlsf_host_model u_tlsf_host_model (.clk_in(clk), .rst_in(rst),
    .go_in(go), .lag_in(lag), .share_in(share), .route_in(route),
    .ref_in(cref), .fwd_on_in(fon), .rev_on_in(ron), .other_in(coth),
    .done_out(done), .ref_out(ref_w), .fwd_n_out(fwd_n),
    .rev_n_out(rev_n), .other_out(other_w));

  // clock 125 MHz
  always #4 clk = ~clk;

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [15:0] mn(input logic [15:0] a,
                                     input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  // write cycle, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er_exp);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (awready && aw) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (wready && w) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    chk(64'(bresp), 64'(er_exp));
  endtask

  // read cycle, expected response noted for the watcher
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    expq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
  endtask

  // hand a command to the host model and let outputs settle
  task automatic drive(input logic [15:0] r);
    cref <= r;
    lag <= 4'($urandom_range(3, 0));
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (done !== 1'b1);
    repeat (3) @(posedge clk);
  endtask

  // watcher: oldest note against each read answer
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (expq.size() == 0) chk(64'({rresp, rdata}), 64'h1_0000_0000);
      else chk(64'({rresp, rdata}), 64'(expq.pop_front()));
    end
  end

  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    test_done;
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, go} = '0;
    {awaddr, araddr, wdata} = '0;
    {share, fon, ron, coth, lag, route, cref} = '0;
    mismatches = 0;
    n_compared = 0;
    ofs = '{tlsf_pkg::OFS_SEL, tlsf_pkg::OFS_FWD_INT, tlsf_pkg::OFS_REV_INT,
            tlsf_pkg::OFS_FWD_EXT, tlsf_pkg::OFS_REV_EXT,
            tlsf_pkg::OFS_MOT_MAX};
    rstv = '{32'(tlsf_pkg::RST_SEL), 32'(tlsf_pkg::RST_INT_LIM),
             32'(tlsf_pkg::RST_INT_LIM), 32'(tlsf_pkg::RST_EXT_LIM),
             32'(tlsf_pkg::RST_EXT_LIM), 32'(tlsf_pkg::RST_MOT_MAX),
             32'h0, 32'h0, 32'h0, 32'h0,
             {tlsf_pkg::RST_INT_LIM, tlsf_pkg::RST_INT_LIM}, 32'h0};
    void'($urandom(9754));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // reset values, then an unmapped place
    for (k = 0; k < 12; k++)
      axi_rd(8'(k * 4), {(k == 11) ? tlsf_pkg::RESP_SLVERR
                         : tlsf_pkg::RESP_OKAY, rstv[k]});
    axi_wr(8'h2c, 32'h5, tlsf_pkg::RESP_SLVERR);
    // random settings, contacts, reference and sharing
    for (it = 0; it < 40; it++) begin
      for (k = 1; k < 5; k++) v[k] = 16'($urandom_range(900, 0));
      v[0] = 16'($urandom_range(4, 0));
      v[5] = 16'($urandom_range(900, 1));
      for (k = 0; k < 6; k++) axi_wr(ofs[k], {16'h0, v[k]}, 2'h0);
      rv = int'($urandom_range(1800, 0)) - 900;
      fon <= 1'($urandom);
      ron <= 1'($urandom);
      share <= 1'($urandom);
      coth <= 3'($urandom);
      route <= v[0][3:0];
      drive(rv[15:0]);
      ef = mn(mn(mn(v[1], 16'h0320), v[5]),
              fon ? mn(v[3], 16'h0320) : 16'hffff);
      er = mn(mn(mn(v[2], 16'h0320), v[5]),
              ron ? mn(v[4], 16'h0320) : 16'hffff);
      fl = (rv >= 0) ? (rv > int'(ef)) : (-rv > int'(er));
      oe = share ? coth : coth & ~(3'h1 << (v[0][3:0] - 4'h1));
      for (k = 0; k < 3; k++) ec[k] = ~((fl && v[0] == 16'(k + 1)) || oe[k]);
      chk(64'(circ_n), 64'(ec));
      chk(64'(fwd_lim), 64'(ef));
      chk(64'(rev_lim), 64'(er));
      axi_rd(tlsf_pkg::OFS_FWD_EXT, {18'h0, mn(v[3], 16'h0320)});
      axi_rd(tlsf_pkg::OFS_REV_EXT, {18'h0, mn(v[4], 16'h0320)});
      axi_rd(tlsf_pkg::OFS_REV_INT, {18'h0, mn(v[2], 16'h0320)});
      axi_rd(tlsf_pkg::OFS_IN_MON, {26'h0, ron, fon, 6'h0});
      axi_rd(tlsf_pkg::OFS_OUT_MON, {30'h0, fl, ~ec});
    end
    // interrupt: rise, fall, clear by writing one, mask
    drive(16'h0000);
    axi_wr(tlsf_pkg::OFS_IRQ_MSK, 32'h3, 2'h0);
    axi_wr(tlsf_pkg::OFS_IRQ_STS, 32'h3, 2'h0);
    axi_rd(tlsf_pkg::OFS_IRQ_STS, 34'h0);
    drive(16'h0321);
    chk(64'(irq), 64'h1);
    axi_rd(tlsf_pkg::OFS_IRQ_STS, 34'h1);
    drive(16'h0000);
    axi_rd(tlsf_pkg::OFS_IRQ_STS, 34'h3);
    axi_wr(tlsf_pkg::OFS_IRQ_STS, 32'h1, 2'h0);
    axi_rd(tlsf_pkg::OFS_IRQ_STS, 34'h2);
    axi_wr(tlsf_pkg::OFS_IRQ_MSK, 32'h1, 2'h0);
    repeat (2) @(posedge clk);
    chk(64'(irq), 64'h0);
    repeat (3) @(posedge clk);
    test_done;
  end
endmodule // tlsf_top_tb
